// ---- design/cfm_clock_fail_monitor.sv ----
// clock fail monitor: supervision, fallback to internal oscillator and wishbone registers
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// The register addresses and register access over Wishbone were decided locally.
`include "cfm_defines.svh"
module cfm_clock_fail_monitor #(
  parameter int LF_DIVIDE = `CFM_LF_DIVIDE,
  parameter int STARTUP_PERIODS = `CFM_STARTUP_PERIODS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wishbone slave
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // configuration straps
  input wire logic monitorEnableFuse,
  input wire logic [2:0] cfgOscMode,
  // core events, one cycle each
  input wire logic sleepExec,
  input wire logic wakeUp,
  // oscillator pins
  input wire logic extClkIn,
  input wire logic lowFreqIntOscIn,
  // clock steering
  output logic [1:0] sysClkSel,
  output logic [3:0] newClockDivider,
  output logic startupRunning,
  output logic oscFailIrq
);

  localparam int HALF = LF_DIVIDE / 2;
  localparam int HW = $clog2(HALF);
  localparam int SW = $clog2(STARTUP_PERIODS);
  localparam logic [HW-1:0] HALF_LAST = HW'(HALF - 1);
  localparam logic [SW-1:0] START_LAST = SW'(STARTUP_PERIODS - 1);

  // ----------------------------------------------------------------
  // mode helpers
  // ----------------------------------------------------------------
  function automatic logic isExternal(input cfm_pkg::cfm_mode_t m);
    isExternal = (m != cfm_pkg::MODE_INTERNAL_HF);
  endfunction

  function automatic logic needsStartup(input cfm_pkg::cfm_mode_t m);
    // external clock inputs need no settling time
    needsStartup = (m == cfm_pkg::MODE_LOW_POWER_CRYSTAL) || (m == cfm_pkg::MODE_CRYSTAL) ||
                   (m == cfm_pkg::MODE_HIGH_SPEED_CRYSTAL) || (m == cfm_pkg::MODE_SECONDARY);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // limitation: the external clock must stay well below half of clk
  logic extMeta_r;
  logic extSync_r;
  logic extPrev_r;
  logic lfMeta_r;
  logic lfSync_r;
  logic lfPrev_r;

  // no reset: the chain tracks the pins through reset, so release brings no false edge
  always_ff @(posedge clk)
  begin
    extMeta_r <= extClkIn;
    extSync_r <= extMeta_r;
    extPrev_r <= extSync_r;
    lfMeta_r <= lowFreqIntOscIn;
    lfSync_r <= lfMeta_r;
    lfPrev_r <= lfSync_r;
  end

  wire extFall = extPrev_r & ~extSync_r;
  wire lfRise = lfSync_r & ~lfPrev_r;

  // ----------------------------------------------------------------
  // sample clock divider
  // ----------------------------------------------------------------
  logic [HW-1:0] lfCount_r;
  logic sampleClk_r;

  wire lfWrap = lfRise & (lfCount_r == HALF_LAST);
  wire sampleRise = lfWrap & ~sampleClk_r;
  wire sampleFall = lfWrap & sampleClk_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lfCount_r <= '0;
      sampleClk_r <= 1'b0;
    end
    else if (lfRise)
    begin
      lfCount_r <= lfWrap ? '0 : lfCount_r + 1'b1;
      sampleClk_r <= sampleClk_r ^ lfWrap;
    end
  end

  // ----------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------
  cfm_pkg::cfm_state_t state_r;
  cfm_pkg::cfm_state_t stateNxt;
  cfm_pkg::cfm_mode_t selMode_r;
  logic [3:0] div_r;
  logic bootLoad_r;
  logic failSafe_r;
  logic failFlag_r;
  logic irqEn_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic [SW-1:0] startCount_r;
  logic [1:0] sysClkSel_r;
  logic startupRunning_r;
  logic irq_r;
  logic failPulse;

  wire wbReq = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wbWr = wbReq & wb_we_i & wb_sel_i[0];
  wire hitCtrl = (wb_adr_i == `CFM_ADDR_CTRL);
  wire hitFlags = (wb_adr_i == `CFM_ADDR_FLAGS);
  wire hitIrqEn = (wb_adr_i == `CFM_ADDR_IRQEN);
  wire hitStatus = (wb_adr_i == `CFM_ADDR_STATUS);
  wire ctrlWr = wbWr & hitCtrl;
  wire flagClr = wbWr & hitFlags & wb_dat_i[`CFM_FLAGS_FAIL_BIT];
  wire irqEnWr = wbWr & hitIrqEn;
  wire [2:0] wrSel = wb_dat_i[`CFM_CTRL_SEL_MSB:`CFM_CTRL_SEL_LSB];
  wire [3:0] wrDiv = wb_dat_i[`CFM_CTRL_DIV_MSB:`CFM_CTRL_DIV_LSB];
  // a rewrite of the same selection still restarts while in fail-safe
  wire selChange = (wrSel != selMode_r) | (wrDiv != div_r) | failSafe_r;
  wire switchReq = ctrlWr & selChange & (state_r != cfm_pkg::ST_SLEEP);
  wire monitorOn = monitorEnableFuse & (state_r == cfm_pkg::ST_RUN_EXT) & isExternal(selMode_r);
  wire startupDone = (state_r == cfm_pkg::ST_STARTUP) & extFall & (startCount_r == START_LAST);
  wire failSeen = failPulse & (state_r == cfm_pkg::ST_RUN_EXT);

  logic [31:0] rdData;
  always_comb
  begin
    rdData = 32'h0;
    if (hitCtrl)
    begin
      rdData[`CFM_CTRL_SEL_MSB:`CFM_CTRL_SEL_LSB] = selMode_r;
      rdData[`CFM_CTRL_DIV_MSB:`CFM_CTRL_DIV_LSB] = div_r;
    end
    else if (hitFlags)
      rdData[`CFM_FLAGS_FAIL_BIT] = failFlag_r;
    else if (hitIrqEn)
      rdData[`CFM_IRQEN_FAIL_BIT] = irqEn_r;
    else if (hitStatus)
    begin
      rdData[`CFM_STAT_FAILSAFE_BIT] = failSafe_r;
      rdData[`CFM_STAT_STARTUP_BIT] = startupRunning_r;
      rdData[`CFM_STAT_SRC_MSB:`CFM_STAT_SRC_LSB] = sysClkSel_r;
      rdData[`CFM_STAT_MONITOR_BIT] = monitorOn;
    end
  end

  // ----------------------------------------------------------------
  // detector
  // ----------------------------------------------------------------
  cfm_fail_detector u_detector (
    .clk(clk),
    .rst(rst),
    .enable(monitorOn),
    .extFall(extFall),
    .sampleRise(sampleRise),
    .sampleFall(sampleFall),
    .failPulse(failPulse)
  );

  // ----------------------------------------------------------------
  // source state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    stateNxt = state_r;
    case (state_r)
      cfm_pkg::ST_START:
        if (bootLoad_r)
          stateNxt = cfm_pkg::ST_START;
        else if (!isExternal(selMode_r))
          stateNxt = cfm_pkg::ST_RUN_INT;
        else if (needsStartup(selMode_r))
          stateNxt = cfm_pkg::ST_STARTUP;
        else
          stateNxt = cfm_pkg::ST_RUN_EXT;
      cfm_pkg::ST_STARTUP:
        if (startupDone)
          stateNxt = cfm_pkg::ST_RUN_EXT;
      cfm_pkg::ST_RUN_EXT:
        if (failSeen)
          stateNxt = cfm_pkg::ST_FAILSAFE;
      cfm_pkg::ST_SLEEP:
        if (wakeUp)
          stateNxt = cfm_pkg::ST_START;
      cfm_pkg::ST_RUN_INT,
      cfm_pkg::ST_FAILSAFE:
        stateNxt = state_r;
      default:
        stateNxt = cfm_pkg::ST_START;
    endcase
    // sleep outranks a selection write in the same cycle
    if (sleepExec && state_r != cfm_pkg::ST_SLEEP)
      stateNxt = cfm_pkg::ST_SLEEP;
    else if (switchReq)
      stateNxt = cfm_pkg::ST_START;
  end

  logic [1:0] srcNxt;
  always_comb
  begin
    case (stateNxt)
      cfm_pkg::ST_RUN_EXT: srcNxt = cfm_pkg::SRC_EXTERNAL;
      cfm_pkg::ST_FAILSAFE: srcNxt = cfm_pkg::SRC_HF_1MHZ;
      default: srcNxt = cfm_pkg::SRC_INTERNAL;
    endcase
  end

  // fail-safe ends on sleep, on a switch to internal, or once the external switch lands
  wire fsClear = sleepExec | (switchReq & !isExternal(cfm_pkg::cfm_mode_t'(wrSel))) |
                 (state_r != cfm_pkg::ST_RUN_EXT && stateNxt == cfm_pkg::ST_RUN_EXT);
  wire failSafeNxt = failSeen | (failSafe_r & ~fsClear);
  // hardware set wins over a software clear in the same cycle
  wire failFlagNxt = failSeen | (failFlag_r & ~flagClr);
  wire irqEnNxt = irqEnWr ? wb_dat_i[`CFM_IRQEN_FAIL_BIT] : irqEn_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= cfm_pkg::ST_START;
      selMode_r <= cfm_pkg::cfm_mode_t'(`CFM_MODE_RESET);
      div_r <= `CFM_CTRL_DIV_RESET;
      bootLoad_r <= 1'b1;
      failSafe_r <= 1'b0;
      failFlag_r <= 1'b0;
      irqEn_r <= 1'b0;
    end
    else
    begin
      state_r <= stateNxt;
      bootLoad_r <= 1'b0;
      if (bootLoad_r)
        selMode_r <= cfm_pkg::cfm_mode_t'(cfgOscMode);
      else if (switchReq)
        selMode_r <= cfm_pkg::cfm_mode_t'(wrSel);
      if (switchReq)
        div_r <= wrDiv;
      failSafe_r <= failSafeNxt;
      failFlag_r <= failFlagNxt;
      irqEn_r <= irqEnNxt;
    end
  end

  // ----------------------------------------------------------------
  // startup timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      startCount_r <= '0;
    else if (state_r != cfm_pkg::ST_STARTUP)
      startCount_r <= '0;
    else if (extFall)
      startCount_r <= startCount_r + 1'b1;
  end

  // ----------------------------------------------------------------
  // outputs and bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sysClkSel_r <= cfm_pkg::SRC_INTERNAL;
      startupRunning_r <= 1'b0;
      irq_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end
    else
    begin
      sysClkSel_r <= srcNxt;
      startupRunning_r <= (stateNxt == cfm_pkg::ST_STARTUP);
      irq_r <= failFlagNxt & irqEnNxt;
      ack_r <= wbReq;
      if (wbReq)
        dat_r <= wb_we_i ? 32'h0 : rdData;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign sysClkSel = sysClkSel_r;
  assign newClockDivider = div_r;
  assign startupRunning = startupRunning_r;
  assign oscFailIrq = irq_r;

endmodule

// ---- design/cfm_defines.svh ----
// register map, field positions, reset values and timing counts of the clock fail monitor
`ifndef CFM_DEFINES_SVH
`define CFM_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CFM_ADDR_CTRL 4'h0
`define CFM_ADDR_FLAGS 4'h4
`define CFM_ADDR_IRQEN 4'h8
`define CFM_ADDR_STATUS 4'hc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFM_CTRL_SEL_LSB 0
`define CFM_CTRL_SEL_MSB 2
`define CFM_CTRL_DIV_LSB 4
`define CFM_CTRL_DIV_MSB 7
`define CFM_FLAGS_FAIL_BIT 0
`define CFM_IRQEN_FAIL_BIT 0
`define CFM_STAT_FAILSAFE_BIT 0
`define CFM_STAT_STARTUP_BIT 1
`define CFM_STAT_SRC_LSB 2
`define CFM_STAT_SRC_MSB 3
`define CFM_STAT_MONITOR_BIT 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CFM_CTRL_DIV_RESET 4'h0
`define CFM_MODE_RESET 3'h0

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define CFM_LF_DIVIDE 64
`define CFM_STARTUP_PERIODS 1024

`endif

// ---- design/cfm_pkg.sv ----
// types shared by the clock fail monitor files
package cfm_pkg;

  typedef enum logic [2:0] {
    MODE_INTERNAL_HF = 3'h0,
    MODE_LOW_POWER_CRYSTAL = 3'h1,
    MODE_CRYSTAL = 3'h2,
    MODE_HIGH_SPEED_CRYSTAL = 3'h3,
    MODE_EXT_CLOCK_LOW = 3'h4,
    MODE_EXT_CLOCK_MEDIUM = 3'h5,
    MODE_EXT_CLOCK_HIGH = 3'h6,
    MODE_SECONDARY = 3'h7
  } cfm_mode_t;

  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'h0,
    SRC_EXTERNAL = 2'h1,
    SRC_HF_1MHZ = 2'h2
  } cfm_clksrc_t;

  typedef enum logic [5:0] {
    ST_START = 6'h01,
    ST_STARTUP = 6'h02,
    ST_RUN_EXT = 6'h04,
    ST_RUN_INT = 6'h08,
    ST_FAILSAFE = 6'h10,
    ST_SLEEP = 6'h20
  } cfm_state_t;

endpackage

// ---- design/cfm_fail_detector.sv ----
// detector latch comparing external clock falling edges against the sample clock
module cfm_fail_detector (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic enable,
  // events, one cycle each
  input wire logic extFall,
  input wire logic sampleRise,
  input wire logic sampleFall,
  // result
  output logic failPulse
);

  logic latch_r;
  logic armed_r;
  logic failPulse_r;
  logic latchNxt;
  logic armedNxt;
  logic failNxt;

  // a falling edge in the same cycle as the sample rise keeps the latch set
  assign latchNxt = enable & (extFall | (latch_r & ~sampleRise));
  // a check needs a whole half period measured from a rise
  assign armedNxt = enable & (armed_r | sampleRise);
  assign failNxt = enable & armed_r & sampleFall & ~latch_r & ~extFall;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      latch_r <= 1'b0;
      armed_r <= 1'b0;
      failPulse_r <= 1'b0;
    end
    else
    begin
      latch_r <= latchNxt;
      armed_r <= armedNxt;
      failPulse_r <= failNxt;
    end
  end

  assign failPulse = failPulse_r;

endmodule

// ---- test/cfm_ext_osc.sv ----
// external oscillator model driving the monitored clock pin
module cfm_ext_osc #(
  parameter int HALF_NS = 75
) (
  // control
  input wire logic run,
  // oscillator pin
  output logic clkOut
);
  timeunit 1ns;
  timeprecision 1ps;
  // a stopped oscillator parks at its last level, as a dead crystal does
  initial
  begin
    clkOut = 1'b0;
    #7;
    forever #HALF_NS if (run) clkOut = ~clkOut;
  end
endmodule

// ---- test/cfm_fail_chk_monitor.sv ----
// checker watching the ports of the clock fail monitor
module cfm_fail_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wishbone
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // straps and events
  input wire logic monitorEnableFuse,
  input wire logic [2:0] cfgOscMode,
  input wire logic sleepExec,
  input wire logic wakeUp,
  // pins and steering
  input wire logic extClkIn,
  input wire logic lowFreqIntOscIn,
  input wire logic [1:0] sysClkSel,
  input wire logic [3:0] newClockDivider,
  input wire logic startupRunning,
  input wire logic oscFailIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic extPrev_r;
  logic [7:0] quiet_r;
  wire ctrlReq = wb_cyc_i && wb_stb_i && wb_we_i && (wb_adr_i == 4'h0);
  // cycles since the pin last moved; a live clock keeps this small
  always_ff @(posedge clk)
  begin
    extPrev_r <= extClkIn;
    quiet_r <= (rst || extClkIn != extPrev_r) ? 8'h00 : (quiet_r == 8'hff ? quiet_r : quiet_r + 8'h01);
  end
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_reset_values: assert property ($fell(rst) |-> sysClkSel == 2'h0 && newClockDivider == 4'h0 && !oscFailIrq)
    else $error("outputs not cleared by reset");
  a_fuse_off: assert property (!monitorEnableFuse && sysClkSel != 2'h2 |=> sysClkSel != 2'h2)
    else $error("fallback with monitor disabled");
  a_startup_internal: assert property (startupRunning |-> sysClkSel == 2'h0)
    else $error("clock not internal during startup");
  a_failsafe_holds: assert property (sysClkSel == 2'h2 && !ctrlReq && !sleepExec && !wakeUp |=> sysClkSel == 2'h2)
    else $error("fail-safe left without cause");
  a_sleep_clears: assert property (sleepExec |=> sysClkSel != 2'h2)
    else $error("sleep did not clear fail-safe");
  a_extmode_skip: assert property ($fell(rst) && cfgOscMode inside {3'h4, 3'h5, 3'h6} |-> ##[1:4] sysClkSel == 2'h1)
    else $error("external clock mode did not switch at once");
  a_crystal_startup: assert property ($fell(rst) && cfgOscMode inside {3'h1, 3'h2, 3'h3, 3'h7} |-> ##[1:4] startupRunning)
    else $error("startup timer did not run");
  a_no_false_fail: assert property (sysClkSel == 2'h1 && quiet_r < 8'h08 |=> sysClkSel != 2'h2)
    else $error("failure declared on a live clock");
endmodule

// ---- test/cfm_clock_fail_monitor_tb_top.sv ----
// testbench of the clock fail monitor with its oscillator partner
module cfm_clock_fail_monitor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic fuse = 1'b1;
  logic [2:0] mode = 3'h0;
  logic sleepP = 1'b0;
  logic wakeP = 1'b0;
  logic extRun = 1'b1;
  logic lfOsc = 1'b0;
  logic extClk, ack, stRun, irq;
  logic [31:0] rdat, q;
  logic [1:0] clkSel;
  logic [3:0] divOut;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  initial forever #12.5 clk = ~clk;
  // low-freq oscillator: 10 clocks a period, phase unrelated to clk
  initial
  begin
    #3;
    forever #125 lfOsc = ~lfOsc;
  end
  cfm_ext_osc #(.HALF_NS(75)) osc_u (.run(extRun), .clkOut(extClk));
  cfm_clock_fail_monitor #(.LF_DIVIDE(8), .STARTUP_PERIODS(16)) dut_u (.clk(clk), .rst(rst), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
    .wb_ack_o(ack), .monitorEnableFuse(fuse), .cfgOscMode(mode), .sleepExec(sleepP), .wakeUp(wakeP),
    .extClkIn(extClk), .lowFreqIntOscIn(lfOsc), .sysClkSel(clkSel), .newClockDivider(divOut),
    .startupRunning(stRun), .oscFailIrq(irq));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wb_xfer(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    we <= w;
    wdat <= d;
    sel <= 4'hf;
    cyc <= 1'b1;
    stb <= 1'b1;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic do_reset(input logic [2:0] m, input logic f);
    @(posedge clk);
    rst <= 1'b1;
    mode <= m;
    fuse <= f;
    extRun <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic wait_sel(input logic [1:0] v);
    int i;
    for (i = 0; i < 400 && clkSel !== v; i++) @(posedge clk);
    #1;
    chk("sysClkSel", 32'(v), 32'(clkSel));
  endtask
  task automatic t_sleep;
    do_reset(3'h5, 1'b0);
    wb_xfer(4'h4, 1'b0, 32'h0);
    chk("flagsReset", 32'h0, q);
    wb_xfer(4'h2, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
    wait_sel(2'h1);
    extRun <= 1'b0;
    repeat (300) @(posedge clk);
    chk("sysClkSel", 32'h1, 32'(clkSel));
    fuse <= 1'b1;
    wait_sel(2'h2);
    chk("irqMasked", 32'h0, 32'(irq));
    @(posedge clk);
    sleepP <= 1'b1;
    @(posedge clk);
    sleepP <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("sleepSel", 32'h0, 32'(clkSel));
    extRun <= 1'b1;
    repeat (20) @(posedge clk);
    wakeP <= 1'b1;
    @(posedge clk);
    wakeP <= 1'b0;
    wait_sel(2'h1);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 8; m++)
    begin
      do_reset(3'(m), 1'b1);
      chk("startupRunning", 32'(m inside {1, 2, 3, 7}), 32'(stRun));
      extRun <= (m == 0) ? 1'b0 : 1'b1;
      if (m == 0)
      begin
        repeat (300) @(posedge clk);
        chk("sysClkSel", 32'h0, 32'(clkSel));
      end
      else
      begin
        wait_sel(2'h1);
        extRun <= 1'b0;
        wait_sel(2'h2);
      end
    end
  endtask
  task automatic t_fail;
    int n;
    do_reset(3'h2, 1'b1);
    for (n = 0; n < 400 && stRun === 1'b1; n++) @(posedge clk);
    chk("startupLength", 32'h1, 32'(n >= 84 && n <= 104));
    wait_sel(2'h1);
    wb_xfer(4'hc, 1'b0, 32'h0);
    chk("status", 32'h14, q);
    wb_xfer(4'h8, 1'b1, 32'h1);
    extRun <= 1'b0;
    wait_sel(2'h2);
    @(posedge clk);
    #1;
    chk("irq", 32'h1, 32'(irq));
    wb_xfer(4'h4, 1'b0, 32'h0);
    chk("flags", 32'h1, q);
    wb_xfer(4'h4, 1'b1, 32'h1);
    wb_xfer(4'h4, 1'b0, 32'h0);
    chk("flagsCleared", 32'h0, q);
    chk("irqCleared", 32'h0, 32'(irq));
    repeat (100) @(posedge clk);
    chk("sysClkSel", 32'h2, 32'(clkSel));
    wb_xfer(4'h0, 1'b1, 32'h4);
    repeat (5) @(posedge clk);
    wait_sel(2'h2);
    wb_xfer(4'h4, 1'b0, 32'h0);
    chk("flagsAgain", 32'h1, q);
    wb_xfer(4'h4, 1'b1, 32'h1);
    wb_xfer(4'h0, 1'b1, 32'h32);
    // oscillator still dead: the startup wait must not turn into a failure
    repeat (200) @(posedge clk);
    #1;
    chk("noFailInStartup", 32'h1, 32'(stRun && clkSel == 2'h0));
    extRun <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("startupAgain", 32'h1, 32'(stRun && clkSel == 2'h0));
    wb_xfer(4'hc, 1'b0, 32'h0);
    chk("failSafeHeld", 32'h1, q & 32'h1);
    wait_sel(2'h1);
    wb_xfer(4'hc, 1'b0, 32'h0);
    chk("status", 32'h14, q);
    chk("divider", 32'h3, 32'(divOut));
  endtask
  initial
  begin
    t_sleep;
    t_modes;
    t_fail;
    final_report;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      final_report;
    end
  end
endmodule
bind cfm_clock_fail_monitor cfm_fail_chk chk_u (.clk(clk), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .monitorEnableFuse(monitorEnableFuse), .cfgOscMode(cfgOscMode), .sleepExec(sleepExec),
  .wakeUp(wakeUp), .extClkIn(extClkIn), .lowFreqIntOscIn(lowFreqIntOscIn), .sysClkSel(sysClkSel),
  .newClockDivider(newClockDivider), .startupRunning(startupRunning), .oscFailIrq(oscFailIrq));
